//--- rtl/apm_pkg.sv
// Shared constants and types of the address port pin multiplexer.
package apm_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int PIN_COUNT = 16;
	localparam int BUS_ADDR_W = 5;
	localparam int BUS_DATA_W = 32;
	localparam int REG_IDX_W = 3;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [BUS_ADDR_W-1:0] OFS_DIRECTION = 5'h00;
	localparam logic [BUS_ADDR_W-1:0] OFS_FUNCTION = 5'h04;
	localparam logic [BUS_ADDR_W-1:0] OFS_ADDR_MASK = 5'h08;
	localparam logic [BUS_ADDR_W-1:0] OFS_PIN_LEVEL = 5'h0c;
	localparam logic [BUS_ADDR_W-1:0] OFS_MODE_STAT = 5'h10;
	localparam logic [BUS_ADDR_W-1:0] OFS_OVERRIDE = 5'h14;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [PIN_COUNT-1:0] RST_DIRECTION = 16'h0000;
	localparam logic [PIN_COUNT-1:0] RST_FUNCTION = 16'h0000;
	localparam logic [PIN_COUNT-1:0] RST_OVERRIDE = 16'h0000;
	localparam int MODE_SINGLE_BIT = 0;
	localparam int MODE_NOROM_BIT = 1;
	localparam int MODE_HOLD_BIT = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {
		FUNC_GPIO,
		FUNC_ADDR
	} apm_func_t;

endpackage : apm_pkg

//--- rtl/apm_reg_if.sv
// Register access strobes between the bus slave and the register file.
`timescale 1ns/100ps
interface apm_reg_if;
	import apm_pkg::*;

	logic                          wrStrobe;
	logic [REG_IDX_W-1:0]          regIdx;
	logic [PIN_COUNT-1:0]          wrData;
	logic [PIN_COUNT-1:0]          wrMask;
	logic [PIN_COUNT-1:0]          rdData;
	logic                          rdHit;

	modport bus (
		output wrStrobe,
		output regIdx,
		output wrData,
		output wrMask,
		input  rdData,
		input  rdHit
	);

	modport regs (
		input  wrStrobe,
		input  regIdx,
		input  wrData,
		input  wrMask,
		output rdData,
		output rdHit
	);
endinterface : apm_reg_if

//--- rtl/apm_wb_slave.sv
// Classic Wishbone slave that turns bus cycles into register strobes.
`timescale 1ns/100ps
module apm_wb_slave (
	input  wire logic                           clock,
	input  wire logic                           rst,
	input  wire logic                           partialRst,
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [apm_pkg::BUS_ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [apm_pkg::BUS_DATA_W-1:0] wb_dat_i,
	output logic      [apm_pkg::BUS_DATA_W-1:0] wb_dat_o,
	output logic                                wb_ack_o,
	apm_reg_if.bus                              regPort
);
	import apm_pkg::*;

	typedef enum logic {
		WB_IDLE,
		WB_ACK
	} apm_wb_state_t;

	apm_wb_state_t              state_reg;
	apm_wb_state_t              state_next;
	logic [BUS_DATA_W-1:0]      dat_reg;
	logic [BUS_DATA_W-1:0]      dat_next;

	// A manual or watchdog reset abandons a cycle in flight; no write lands.
	always_comb begin
		state_next = state_reg;
		dat_next = dat_reg;
		case (state_reg)
			WB_IDLE: begin
				if (wb_cyc_i && wb_stb_i && !partialRst) begin
					state_next = WB_ACK;
					dat_next = regPort.rdHit ? {{(BUS_DATA_W-PIN_COUNT){1'b0}}, regPort.rdData} : '0;
				end
			end
			WB_ACK: begin
				state_next = WB_IDLE;
			end
			default: begin
				state_next = WB_IDLE;
			end
		endcase
		if (partialRst) begin
			state_next = WB_IDLE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= WB_IDLE;
			dat_reg <= '0;
		end else begin
			state_reg <= state_next;
			dat_reg <= dat_next;
		end
	end

	// The write lands on the edge where the master samples ack.
	// A partial reset in the ack cycle withholds both the ack and the write.
	assign wb_ack_o = (state_reg == WB_ACK) && !partialRst;
	assign wb_dat_o = dat_reg;
	assign regPort.wrStrobe = wb_ack_o && wb_we_i && wb_cyc_i && wb_stb_i;
	assign regPort.regIdx = wb_adr_i[BUS_ADDR_W-1:2];
	assign regPort.wrData = wb_dat_i[PIN_COUNT-1:0];
	assign regPort.wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

endmodule : apm_wb_slave

//--- rtl/apm_pad_mux.sv
// Per-pin selection between general-purpose drive and address output.
`timescale 1ns/100ps
module apm_pad_mux #(
	parameter int PINS = 16
) (
	input  wire logic [PINS-1:0] funcBits,
	input  wire logic [PINS-1:0] dirBits,
	input  wire logic            singleChip,
	input  wire logic            noRom,
	input  wire logic [PINS-1:0] gpioOut,
	input  wire logic [PINS-1:0] cpuAddr,
	output logic      [PINS-1:0] addrSel,
	output logic      [PINS-1:0] padOutNext,
	output logic      [PINS-1:0] padOeNext
);
	import apm_pkg::*;

	for (genvar n = 0; n < PINS; n++) begin : g_pin
		apm_func_t pinFunc;

		// Single chip wins over no-ROM: without an external bus there is nothing to address.
		always_comb begin
			if (singleChip) begin
				pinFunc = FUNC_GPIO;
			end else if (noRom) begin
				pinFunc = FUNC_ADDR;
			end else begin
				pinFunc = funcBits[n] ? FUNC_ADDR : FUNC_GPIO;
			end
		end

		assign addrSel[n] = (pinFunc == FUNC_ADDR);
		// Direction bit is ignored outside general-purpose mode.
		assign padOeNext[n] = addrSel[n] ? 1'b1 : dirBits[n];
		assign padOutNext[n] = addrSel[n] ? cpuAddr[n] : (dirBits[n] & gpioOut[n]);
	end

endmodule : apm_pad_mux

//--- rtl/apm_pin_mux.sv
// Top of the address port pin multiplexer: registers, pin stage and bus.
`timescale 1ns/100ps
// --------------------------------------------------------------------
// Overview of operation
// - Sixteen-bit read/write direction register, bit n steers pin n.
// - In general-purpose mode, direction one drives the pin, zero makes it input.
// - Direction bit has no effect while the pin carries the address.
// - Power-on reset clears direction to zero, every pin an input.
// - Manual, watchdog, standby and sleep leave direction untouched.
// - Sixteen-bit read/write function register, bit n selects pin n function.
// - Power-on reset clears function to zero, every pin general-purpose.
// - Manual, watchdog, standby and sleep leave function untouched.
// - Function zero is general-purpose, one puts address bit n on pin n.
// - Single chip mode keeps every pin general-purpose whatever the function bit.
// - No-ROM mode without single chip mode drives the address on every pin whatever the function bit.
// --------------------------------------------------------------------
module apm_pin_mux #(
	parameter int PINS = 16
) (
	input  wire logic                           clock,
	input  wire logic                           rst,
	input  wire logic                           partialRst,
	input  wire logic                           lowPowerHold,
	input  wire logic                           singleChipPin,
	input  wire logic                           noRomPin,
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [apm_pkg::BUS_ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [apm_pkg::BUS_DATA_W-1:0] wb_dat_i,
	output logic      [apm_pkg::BUS_DATA_W-1:0] wb_dat_o,
	output logic                                wb_ack_o,
	input  wire logic [PINS-1:0]                cpuAddr,
	input  wire logic [PINS-1:0]                gpioOut,
	output logic      [PINS-1:0]                gpioIn,
	input  wire logic [PINS-1:0]                padIn,
	output logic      [PINS-1:0]                padOut,
	output logic      [PINS-1:0]                padOe
);
	import apm_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (PINS != PIN_COUNT) begin : g_bad_pins
		$error("apm_pin_mux serves exactly sixteen pins");
	end
	if (REG_IDX_W != BUS_ADDR_W - 2) begin : g_bad_idx
		$error("apm_pin_mux word index must be the byte address without its two low bits");
	end
	if (BUS_DATA_W < PINS) begin : g_bad_data
		$error("apm_pin_mux bus data must be at least as wide as the port");
	end
	if (MODE_HOLD_BIT >= PINS || MODE_SINGLE_BIT == MODE_NOROM_BIT) begin : g_bad_mode
		$error("apm_pin_mux mode status bits must be distinct and inside the word");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	apm_reg_if regPort ();

	logic [PINS-1:0]       dir_reg;
	logic [PINS-1:0]       dir_next;
	logic [PINS-1:0]       func_reg;
	logic [PINS-1:0]       func_next;
	logic [PINS-1:0]       ovr_reg;
	logic [PINS-1:0]       ovr_next;
	logic [PINS-1:0]       ovrSet;
	logic [PINS-1:0]       ovrClr;

	logic [PINS-1:0]       dirMerged;
	logic [PINS-1:0]       funcMerged;
	logic [PINS-1:0]       ovrWrOnes;
	logic [PINS-1:0]       pinIsInput;
	logic [PINS-1:0]       modeWord;

	logic [1:0]            modeMeta_reg;
	logic [1:0]            modeMeta_next;
	logic [1:0]            mode_reg;
	logic [1:0]            mode_next;
	logic                  singleChip;
	logic                  noRom;

	logic [PINS-1:0]       padMeta_reg;
	logic [PINS-1:0]       padMeta_next;
	logic [PINS-1:0]       padSync_reg;
	logic [PINS-1:0]       padSync_next;
	logic [PINS-1:0]       gpioIn_reg;
	logic [PINS-1:0]       gpioIn_next;

	logic [PINS-1:0]       padOut_reg;
	logic [PINS-1:0]       padOut_next;
	logic [PINS-1:0]       padOe_reg;
	logic [PINS-1:0]       padOe_next;
	logic [PINS-1:0]       addrSel;
	logic [PINS-1:0]       muxOut;
	logic [PINS-1:0]       muxOe;

	logic                  wrDir;
	logic                  wrFunc;
	logic                  wrOvr;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	apm_wb_slave u_wb (
		.clock      (clock),
		.rst        (rst),
		.partialRst (partialRst),
		.wb_cyc_i   (wb_cyc_i),
		.wb_stb_i   (wb_stb_i),
		.wb_we_i    (wb_we_i),
		.wb_adr_i   (wb_adr_i),
		.wb_sel_i   (wb_sel_i),
		.wb_dat_i   (wb_dat_i),
		.wb_dat_o   (wb_dat_o),
		.wb_ack_o   (wb_ack_o),
		.regPort    (regPort.bus)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// Offsets are word aligned, so the word index is the offset shifted down.
	always_comb begin
		wrDir = 1'b0;
		wrFunc = 1'b0;
		wrOvr = 1'b0;
		if (regPort.wrStrobe) begin
			case (regPort.regIdx)
				OFS_DIRECTION[BUS_ADDR_W-1:2]: begin
					wrDir = 1'b1;
				end
				OFS_FUNCTION[BUS_ADDR_W-1:2]: begin
					wrFunc = 1'b1;
				end
				OFS_OVERRIDE[BUS_ADDR_W-1:2]: begin
					wrOvr = 1'b1;
				end
				default: begin
					wrDir = 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Byte-lane write merge
	// ----------------------------------------------------------------
	// A lane whose select is low keeps its old bits, so software may
	// rewrite the upper or lower eight pins alone.
	always_comb begin
		dirMerged = (dir_reg & ~regPort.wrMask) | (regPort.wrData & regPort.wrMask);
		funcMerged = (func_reg & ~regPort.wrMask) | (regPort.wrData & regPort.wrMask);
		ovrWrOnes = regPort.wrData & regPort.wrMask;
	end

	// ----------------------------------------------------------------
	// Direction and function registers
	// ----------------------------------------------------------------
	// Only the power-on reset touches these; the partial reset and the
	// low-power hold are deliberately absent from their equations.
	always_comb begin
		dir_next = dir_reg;
		if (wrDir) begin
			dir_next = dirMerged;
		end
	end

	always_comb begin
		func_next = func_reg;
		if (wrFunc) begin
			func_next = funcMerged;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dir_reg <= RST_DIRECTION;
			func_reg <= RST_FUNCTION;
		end else begin
			dir_reg <= dir_next;
			func_reg <= func_next;
		end
	end

	// ----------------------------------------------------------------
	// Mode pin synchroniser
	// ----------------------------------------------------------------
	always_comb begin
		modeMeta_next = {noRomPin, singleChipPin};
		mode_next = modeMeta_reg;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			modeMeta_reg <= 2'h0;
			mode_reg <= 2'h0;
		end else begin
			modeMeta_reg <= modeMeta_next;
			mode_reg <= mode_next;
		end
	end

	assign singleChip = mode_reg[MODE_SINGLE_BIT];
	assign noRom = mode_reg[MODE_NOROM_BIT];

	// ----------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------
	// The level is presented to the port data logic only for pins that are
	// general-purpose inputs; others read zero so stale pad noise never leaks.
	// A pin counts as an input only in general-purpose mode with its direction bit clear.
	for (genvar n = 0; n < PINS; n++) begin : g_in
		assign pinIsInput[n] = !addrSel[n] && !dir_reg[n];
	end

	always_comb begin
		padMeta_next = padIn;
		padSync_next = padMeta_reg;
		gpioIn_next = padSync_reg & pinIsInput;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			padMeta_reg <= '0;
			padSync_reg <= '0;
			gpioIn_reg <= '0;
		end else begin
			padMeta_reg <= padMeta_next;
			padSync_reg <= padSync_next;
			gpioIn_reg <= gpioIn_next;
		end
	end

	assign gpioIn = gpioIn_reg;

	// ----------------------------------------------------------------
	// Pin function selection
	// ----------------------------------------------------------------
	apm_pad_mux #(
		.PINS (PINS)
	) u_mux (
		.funcBits   (func_reg),
		.dirBits    (dir_reg),
		.singleChip (singleChip),
		.noRom      (noRom),
		.gpioOut    (gpioOut),
		.cpuAddr    (cpuAddr),
		.addrSel    (addrSel),
		.padOutNext (muxOut),
		.padOeNext  (muxOe)
	);

	// ----------------------------------------------------------------
	// Pad output stage
	// ----------------------------------------------------------------
	// One register stage keeps the pads glitch free; the address reaches
	// the pin one clock after the core drives it.
	always_comb begin
		padOut_next = muxOut;
		padOe_next = muxOe;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			padOut_reg <= '0;
			padOe_reg <= '0;
		end else begin
			padOut_reg <= padOut_next;
			padOe_reg <= padOe_next;
		end
	end

	assign padOut = padOut_reg;
	assign padOe = padOe_reg;

	// ----------------------------------------------------------------
	// Mode override flags
	// ----------------------------------------------------------------
	// A flag records that a mode pin forced a pin against its function bit.
	// Software clears a flag by writing one; a fresh set in that cycle wins.
	always_comb begin
		ovrSet = func_reg ^ addrSel;
		ovrClr = wrOvr ? ovrWrOnes : '0;
		ovr_next = (ovr_reg & ~ovrClr) | ovrSet;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ovr_reg <= RST_OVERRIDE;
		end else begin
			ovr_reg <= ovr_next;
		end
	end

	// ----------------------------------------------------------------
	// Mode status word
	// ----------------------------------------------------------------
	// Software sees the synchronised mode, the same value that steers the
	// pads, never the raw pins, so a read cannot disagree with the pads.
	always_comb begin
		modeWord = '0;
		modeWord[MODE_SINGLE_BIT] = singleChip;
		modeWord[MODE_NOROM_BIT] = noRom;
		modeWord[MODE_HOLD_BIT] = lowPowerHold;
	end

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	// Unmapped words answer with zero so a stray read is harmless.
	always_comb begin
		regPort.rdData = '0;
		regPort.rdHit = 1'b1;
		case (regPort.regIdx)
			OFS_DIRECTION[BUS_ADDR_W-1:2]: begin
				regPort.rdData = dir_reg;
			end
			OFS_FUNCTION[BUS_ADDR_W-1:2]: begin
				regPort.rdData = func_reg;
			end
			OFS_ADDR_MASK[BUS_ADDR_W-1:2]: begin
				regPort.rdData = addrSel;
			end
			OFS_PIN_LEVEL[BUS_ADDR_W-1:2]: begin
				regPort.rdData = padSync_reg;
			end
			OFS_MODE_STAT[BUS_ADDR_W-1:2]: begin
				regPort.rdData = modeWord;
			end
			OFS_OVERRIDE[BUS_ADDR_W-1:2]: begin
				regPort.rdData = ovr_reg;
			end
			default: begin
				regPort.rdHit = 1'b0;
			end
		endcase
	end

endmodule : apm_pin_mux

//--- testbench/apm_pin_mux_monitor.sv
// Concurrent checks on the ports of the address port pin multiplexer.
`timescale 1ns/100ps
module apm_pin_mux_monitor #(
	parameter int PINS = 16
) (
	input wire logic                           clock,
	input wire logic                           rst,
	input wire logic                           partialRst,
	input wire logic                           singleChipPin,
	input wire logic                           noRomPin,
	input wire logic                           wb_cyc_i,
	input wire logic                           wb_stb_i,
	input wire logic                           wb_we_i,
	input wire logic [apm_pkg::BUS_DATA_W-1:0] wb_dat_o,
	input wire logic                           wb_ack_o,
	input wire logic [PINS-1:0]                cpuAddr,
	input wire logic [PINS-1:0]                gpioOut,
	input wire logic [PINS-1:0]                padOut,
	input wire logic [PINS-1:0]                padOe
);
	import apm_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Mode pins pass a two-flop synchroniser, so four samples settle the pads.
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) && !partialRst |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_partial_refuse: assert property (partialRst |=> !wb_ack_o)
		else $error("ack after partial reset");
	a_partial_quiet: assert property (partialRst |-> !wb_ack_o)
		else $error("ack given during partial reset");
	a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_drive_enabled: assert property ((padOut & ~padOe) == '0)
		else $error("pad data high on undriven pin");
	a_norom_addr: assert property ((noRomPin && !singleChipPin)[*4] |-> padOe == {PINS{1'b1}} && padOut == $past(cpuAddr))
		else $error("address not on pads in no-ROM mode");
	a_single_gpio: assert property (singleChipPin[*4] |-> padOut == (padOe & $past(gpioOut)))
		else $error("pads not general-purpose in single chip mode");
	c_write: cover property (wb_ack_o && wb_we_i);
	c_norom: cover property (noRomPin && padOe == {PINS{1'b1}});
	c_single: cover property (singleChipPin && padOe != '0);
	c_abort: cover property (wb_cyc_i && wb_stb_i && partialRst);
endmodule : apm_pin_mux_monitor

bind apm_pin_mux apm_pin_mux_monitor #(.PINS(PINS)) i_mon (.clock(clock), .rst(rst), .partialRst(partialRst),
	.singleChipPin(singleChipPin), .noRomPin(noRomPin), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuAddr(cpuAddr), .gpioOut(gpioOut), .padOut(padOut), .padOe(padOe));

//--- testbench/apm_pad_partner.sv
// Board-side model of the port pins.
`timescale 1ns/100ps
module apm_pad_partner #(
	parameter int PINS = 16
) (
	input wire logic [PINS-1:0] padOut,
	input wire logic [PINS-1:0] padOe,
	input wire logic [PINS-1:0] extLevel,
	output logic     [PINS-1:0] padIn
);
	// A driven pin reads back its own drive; an input pin sees the board level.
	assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule : apm_pad_partner

//--- testbench/tb_apm_pin_mux.sv
// Self-checking bench of the address port pin multiplexer.
`timescale 1ns/100ps
module tb_apm_pin_mux;
	import apm_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                  clock = 0, rst = 1, partialRst = 0, lowPowerHold = 0, singleChipPin = 0, noRomPin = 0;
	logic                  wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [BUS_ADDR_W-1:0] wb_adr_i = '0;
	logic [3:0]            wb_sel_i = '0;
	logic [BUS_DATA_W-1:0] wb_dat_i = '0, wb_dat_o;
	logic [PIN_COUNT-1:0]  cpuAddr = '0, gpioOut = '0, extLevel = '0, gpioIn, padIn, padOut, padOe, dirVal, funcVal;
	logic [BUS_DATA_W-1:0] expQ[$];
	int                    num_errors = 0, cmp_count = 0, cycles = 0;

	always #2.5 clock = ~clock;

	apm_pin_mux #(.PINS(PIN_COUNT)) i_dut (.clock(clock), .rst(rst), .partialRst(partialRst),
		.lowPowerHold(lowPowerHold), .singleChipPin(singleChipPin), .noRomPin(noRomPin), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpuAddr(cpuAddr), .gpioOut(gpioOut), .gpioIn(gpioIn),
		.padIn(padIn), .padOut(padOut), .padOe(padOe));
	apm_pad_partner #(.PINS(PIN_COUNT)) i_board (.padOut(padOut), .padOe(padOe), .extLevel(extLevel), .padIn(padIn));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// The request is held until ack is seen, however long the slave takes.
	task automatic xfer(input logic we, input logic [4:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		do begin
			@(posedge clock);
		end while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [4:0] adr, input logic [15:0] exp);
		expQ.push_back({16'h0000, exp});
		xfer(1'b0, adr, 4'hf, 32'h0);
	endtask : rd

	task automatic pads(input logic [15:0] eOe, input logic [15:0] eOut);
		// Mode sync, pad register and the three input flops need six edges.
		repeat (7) @(posedge clock);
		@(negedge clock);
		check("padOe", {16'h0000, eOe}, {16'h0000, padOe});
		check("padOut", {16'h0000, eOut}, {16'h0000, padOut});
		check("gpioIn", {16'h0000, extLevel & ~eOe}, {16'h0000, gpioIn});
		@(posedge clock);
	endtask : pads

	function automatic logic [15:0] mixOut(input logic [15:0] d, input logic [15:0] f);
		return (f & cpuAddr) | (~f & d & gpioOut);
	endfunction : mixOut

	// ----------------------------------------------------------------
	// Read results and hang guard
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			if (expQ.size() == 0) check("unexpected read", 32'h0, 32'h1);
			else check("read data", expQ.pop_front(), wb_dat_o);
		end
		cycles++;
		if (cycles == 5000) begin
			check("timeout", 32'h0, 32'h1);
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(13));
		cpuAddr <= 16'($urandom);
		gpioOut <= 16'($urandom);
		extLevel <= 16'($urandom);
		dirVal = 16'($urandom);
		funcVal = 16'($urandom);
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(OFS_DIRECTION, 16'h0000);
		rd(OFS_FUNCTION, 16'h0000);
		pads(16'h0000, 16'h0000);
		xfer(1'b1, OFS_DIRECTION, 4'hf, {16'h0000, dirVal});
		rd(OFS_DIRECTION, dirVal);
		pads(dirVal, dirVal & gpioOut);
		xfer(1'b1, OFS_DIRECTION, 4'h1, {16'h0000, ~dirVal});
		dirVal[7:0] = ~dirVal[7:0];
		rd(OFS_DIRECTION, dirVal);
		xfer(1'b1, 5'h18, 4'hf, 32'hffffffff);
		rd(5'h18, 16'h0000);
		xfer(1'b1, OFS_FUNCTION, 4'hf, {16'h0000, funcVal});
		rd(OFS_FUNCTION, funcVal);
		pads(dirVal | funcVal, mixOut(dirVal, funcVal));
		// A write cut by the partial reset must neither be answered nor land.
		partialRst <= 1'b1;
		lowPowerHold <= 1'b1;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= 1'b1;
		wb_adr_i <= OFS_DIRECTION;
		wb_dat_i <= {16'h0000, ~dirVal};
		@(posedge clock);
		partialRst <= 1'b0;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		rd(OFS_DIRECTION, dirVal);
		rd(OFS_FUNCTION, funcVal);
		rd(OFS_MODE_STAT, 16'h0004);
		lowPowerHold <= 1'b0;
		noRomPin <= 1'b1;
		pads(16'hffff, cpuAddr);
		rd(OFS_ADDR_MASK, 16'hffff);
		rd(OFS_MODE_STAT, 16'h0002);
		rd(OFS_OVERRIDE, ~funcVal);
		xfer(1'b1, OFS_OVERRIDE, 4'hf, 32'h0000ffff);
		rd(OFS_OVERRIDE, ~funcVal);
		singleChipPin <= 1'b1;
		pads(dirVal, dirVal & gpioOut);
		rd(OFS_FUNCTION, funcVal);
		rd(OFS_OVERRIDE, 16'hffff);
		singleChipPin <= 1'b0;
		noRomPin <= 1'b0;
		xfer(1'b1, OFS_OVERRIDE, 4'hf, 32'h0000ffff);
		rd(OFS_OVERRIDE, 16'h0000);
		rd(OFS_ADDR_MASK, funcVal);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		rd(OFS_DIRECTION, 16'h0000);
		rd(OFS_FUNCTION, 16'h0000);
		print_verdict();
	end
endmodule : tb_apm_pin_mux
